// ---- rtl/mft_pkg.sv ----
`default_nettype none
package mft_pkg;
	// Register addresses on the 6-bit register port
	localparam logic [5:0] MFT_ADDR_START_PWM = 6'h20;
	localparam logic [5:0] MFT_ADDR_ALPHA_WAIT = 6'h22;
	localparam logic [5:0] MFT_ADDR_ALPHA_COUNT = 6'h24;
	localparam logic [5:0] MFT_ADDR_ALPHA_PERIOD = 6'h25;
	localparam logic [5:0] MFT_ADDR_BETA_WAIT = 6'h27;
	localparam logic [5:0] MFT_ADDR_BETA_COUNT = 6'h29;
	localparam logic [5:0] MFT_ADDR_BETA_PERIOD = 6'h2A;
	// Field positions
	localparam int MFT_WAIT_LSB = 0;
	localparam int MFT_PWM_DIV_LSB = 8;
	localparam int MFT_PWM_SCALE_LSB = 13;
	localparam int MFT_TRIM_LSB = 8;
	// Values after reset
	localparam logic [7:0] MFT_START_WAIT_RST = 8'h0A;
	localparam logic [7:0] MFT_EXC_WAIT_RST = 8'h03;
	localparam logic [4:0] MFT_PWM_DIV_RST = 5'h1C;
	localparam logic [1:0] MFT_PWM_SCALE_RST = 2'h1;
	localparam logic [5:0] MFT_TRIM_RST = 6'h00;
	localparam logic [7:0] MFT_COUNT_RST = 8'h00;
	localparam logic [15:0] MFT_PERIOD_RST = 16'h0000;
	// Cycle counts
	localparam int MFT_WAIT_UNIT_LOG2 = 13;
	localparam int MFT_FINE_PER_COUNT_LOG2 = 3;
	localparam logic [17:0] MFT_CYCLES_PER_FINE = 18'h00003;
	localparam int MFT_PWM_BASE_LOG2 = 3;
	typedef enum logic [1:0] {MFT_IDLE, MFT_EXC_WAIT, MFT_RUN} mft_motor_state_t;
endpackage
`default_nettype wire

// ---- rtl/mft_frame_timing.sv ----
// What this block does
// - Step period times 768 clocks per electrical cycle
// - Frame motion lasts period times count times 24
// - Frame sync edge cancels unfinished motion
// - Step count sets rotation per frame
// - Start wait lasts n times 8192 clocks
// - Start wait begins at frame sync edge
// - Excitation wait n times 8192 after start wait
// - Motor rotates after its excitation wait ends; zero wait never starts it
// - PWM divider zero acts as one
// - PWM period divider times 8 times 2^scale
// - Per-motor 6-bit phase trim, reset zero
// - Trim is two's complement 0.7 degree steps
// - Count n gives 8n fine steps
// - Count zero stops motor, holds position
`default_nettype none
module mft_frame_timing
	import mft_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic focus_zoom_frame_sync,
	input wire logic reg_wr_en,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wr_data,
	output logic [15:0] reg_rd_data,
	output logic start_wait_flag,
	output logic [1:0] excitation_wait_flag,
	output logic [1:0] motor_running,
	output logic [1:0] fine_step,
	output logic [7:0] alpha_position,
	output logic [7:0] beta_position,
	output logic [5:0] alpha_phase_trim_active,
	output logic [5:0] beta_phase_trim_active,
	output logic pwm_period_start
);
	logic [7:0] start_wait;
	logic [4:0] pwm_divider;
	logic [1:0] pwm_divider_scale;
	logic [7:0] exc_wait [2];
	logic [5:0] phase_trim [2];
	logic [7:0] step_count_per_frame [2];
	logic [15:0] step_period [2];
	logic [7:0] work_exc_wait [2];
	logic [7:0] work_count [2];
	logic [15:0] work_period [2];
	logic [4:0] work_pwm_div;
	logic [1:0] work_pwm_scale;
	logic sync_prev;
	logic fs_edge;
	logic [20:0] sw_cnt;
	logic sw_done;
	logic [10:0] pwm_cnt;
	logic [10:0] pwm_last;

	assign fs_edge = focus_zoom_frame_sync & ~sync_prev;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_wait <= MFT_START_WAIT_RST;
			pwm_divider <= MFT_PWM_DIV_RST;
			pwm_divider_scale <= MFT_PWM_SCALE_RST;
			for (int i = 0; i < 2; i++) begin
				exc_wait[i] <= MFT_EXC_WAIT_RST;
				phase_trim[i] <= MFT_TRIM_RST;
				step_count_per_frame[i] <= MFT_COUNT_RST;
				step_period[i] <= MFT_PERIOD_RST;
			end
		end else if (ce && reg_wr_en) begin
			case (reg_addr)
				MFT_ADDR_START_PWM: begin
					start_wait <= reg_wr_data[MFT_WAIT_LSB +: 8];
					pwm_divider <= reg_wr_data[MFT_PWM_DIV_LSB +: 5];
					pwm_divider_scale <= reg_wr_data[MFT_PWM_SCALE_LSB +: 2];
				end
				MFT_ADDR_ALPHA_WAIT: begin
					exc_wait[0] <= reg_wr_data[MFT_WAIT_LSB +: 8];
					phase_trim[0] <= reg_wr_data[MFT_TRIM_LSB +: 6];
				end
				MFT_ADDR_BETA_WAIT: begin
					exc_wait[1] <= reg_wr_data[MFT_WAIT_LSB +: 8];
					phase_trim[1] <= reg_wr_data[MFT_TRIM_LSB +: 6];
				end
				MFT_ADDR_ALPHA_COUNT: step_count_per_frame[0] <= reg_wr_data[7:0];
				MFT_ADDR_BETA_COUNT: step_count_per_frame[1] <= reg_wr_data[7:0];
				MFT_ADDR_ALPHA_PERIOD: step_period[0] <= reg_wr_data;
				MFT_ADDR_BETA_PERIOD: step_period[1] <= reg_wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rd_data <= 16'h0000;
		end else if (ce) begin
			case (reg_addr)
				MFT_ADDR_START_PWM: reg_rd_data <= {1'b0, pwm_divider_scale, pwm_divider, start_wait};
				MFT_ADDR_ALPHA_WAIT: reg_rd_data <= {2'h0, phase_trim[0], exc_wait[0]};
				MFT_ADDR_BETA_WAIT: reg_rd_data <= {2'h0, phase_trim[1], exc_wait[1]};
				MFT_ADDR_ALPHA_COUNT: reg_rd_data <= {8'h00, step_count_per_frame[0]};
				MFT_ADDR_BETA_COUNT: reg_rd_data <= {8'h00, step_count_per_frame[1]};
				MFT_ADDR_ALPHA_PERIOD: reg_rd_data <= step_period[0];
				MFT_ADDR_BETA_PERIOD: reg_rd_data <= step_period[1];
				default: reg_rd_data <= 16'h0000;
			endcase
		end
	end

	// A zero start wait never arms, so nothing is latched for that frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_prev <= 1'b0;
			start_wait_flag <= 1'b0;
			sw_cnt <= 21'h000000;
			sw_done <= 1'b0;
		end else if (ce) begin
			sync_prev <= focus_zoom_frame_sync;
			sw_done <= 1'b0;
			if (fs_edge && start_wait != 8'h00) begin
				start_wait_flag <= 1'b1;
				sw_cnt <= {start_wait, 13'h0000} - 21'h000001;
			end else if (start_wait_flag) begin
				if (sw_cnt == 21'h000000) begin
					start_wait_flag <= 1'b0;
					sw_done <= 1'b1;
				end else begin
					sw_cnt <= sw_cnt - 21'h000001;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			work_pwm_div <= MFT_PWM_DIV_RST;
			work_pwm_scale <= MFT_PWM_SCALE_RST;
			alpha_phase_trim_active <= MFT_TRIM_RST;
			beta_phase_trim_active <= MFT_TRIM_RST;
			for (int i = 0; i < 2; i++) begin
				work_exc_wait[i] <= MFT_EXC_WAIT_RST;
				work_count[i] <= MFT_COUNT_RST;
				work_period[i] <= MFT_PERIOD_RST;
			end
		end else if (ce && start_wait_flag && sw_cnt == 21'h000000
			&& !(fs_edge && start_wait != 8'h00)) begin
			work_pwm_div <= pwm_divider;
			work_pwm_scale <= pwm_divider_scale;
			alpha_phase_trim_active <= phase_trim[0];
			beta_phase_trim_active <= phase_trim[1];
			for (int i = 0; i < 2; i++) begin
				work_exc_wait[i] <= exc_wait[i];
				work_count[i] <= step_count_per_frame[i];
				work_period[i] <= step_period[i];
			end
		end
	end

	assign pwm_last = ({6'h00, (work_pwm_div == 5'h00) ? 5'h01 : work_pwm_div}
		<< (MFT_PWM_BASE_LOG2 + int'(work_pwm_scale))) - 11'h001;

	// Restart on a new working set so a shorter period never wraps early
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_cnt <= 11'h000;
			pwm_period_start <= 1'b0;
		end else if (ce) begin
			pwm_period_start <= 1'b0;
			if (sw_done) begin
				pwm_cnt <= 11'h000;
			end else if (pwm_cnt >= pwm_last) begin
				pwm_cnt <= 11'h000;
				pwm_period_start <= 1'b1;
			end else begin
				pwm_cnt <= pwm_cnt + 11'h001;
			end
		end
	end

	for (genvar m = 0; m < 2; m++) begin : g_motor
		mft_motor_state_t state;
		logic [20:0] wait_cnt;
		logic [17:0] sub_cnt;
		logic [17:0] sub_last;
		logic [10:0] steps_left;
		logic exc_q;
		logic run_q;
		logic step_q;
		logic [7:0] pos_q;

		// Zero period is run as one so the sub-step counter always terminates
		assign sub_last = 18'(((work_period[m] == 16'h0000) ? 16'h0001 : work_period[m]))
			* MFT_CYCLES_PER_FINE - 18'h00001;

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				state <= MFT_IDLE;
				wait_cnt <= 21'h000000;
				sub_cnt <= 18'h00000;
				steps_left <= 11'h000;
				exc_q <= 1'b0;
				run_q <= 1'b0;
				step_q <= 1'b0;
				pos_q <= 8'h00;
			end else if (ce) begin
				step_q <= 1'b0;
				if (fs_edge) begin
					state <= MFT_IDLE;
					exc_q <= 1'b0;
					run_q <= 1'b0;
				end else begin
					case (state)
						MFT_IDLE: begin
							if (sw_done && work_exc_wait[m] != 8'h00) begin
								state <= MFT_EXC_WAIT;
								exc_q <= 1'b1;
								wait_cnt <= {work_exc_wait[m], 13'h0000} - 21'h000001;
							end
						end
						MFT_EXC_WAIT: begin
							if (wait_cnt == 21'h000000) begin
								exc_q <= 1'b0;
								sub_cnt <= 18'h00000;
								steps_left <= {work_count[m], 3'h0};
								if (work_count[m] != 8'h00) begin
									state <= MFT_RUN;
									run_q <= 1'b1;
								end else begin
									state <= MFT_IDLE;
								end
							end else begin
								wait_cnt <= wait_cnt - 21'h000001;
							end
						end
						MFT_RUN: begin
							if (sub_cnt >= sub_last) begin
								sub_cnt <= 18'h00000;
								step_q <= 1'b1;
								pos_q <= pos_q + 8'h01;
								steps_left <= steps_left - 11'h001;
								if (steps_left == 11'h001) begin
									state <= MFT_IDLE;
									run_q <= 1'b0;
								end
							end else begin
								sub_cnt <= sub_cnt + 18'h00001;
							end
						end
						default: state <= MFT_IDLE;
					endcase
				end
			end
		end

		assign excitation_wait_flag[m] = exc_q;
		assign motor_running[m] = run_q;
		assign fine_step[m] = step_q;
	end

	assign alpha_position = g_motor[0].pos_q;
	assign beta_position = g_motor[1].pos_q;

	// Checking helpers
	logic [20:0] sw_len;
	logic [7:0] sw_arm;
	logic [10:0] tally;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_len <= 21'h000000;
			sw_arm <= 8'h00;
			tally <= 11'h000;
		end else if (ce) begin
			if (fs_edge && start_wait != 8'h00) begin
				sw_len <= 21'h000000;
				sw_arm <= start_wait;
			end else if (start_wait_flag) begin
				sw_len <= sw_len + 21'h000001;
			end
			if (!motor_running[0]) begin
				tally <= 11'h000;
			end else if (g_motor[0].sub_cnt >= g_motor[0].sub_last) begin
				tally <= tally + 11'h001;
			end
		end
	end

	property p_sw_start;
		@(posedge clk) disable iff (rst) ce && fs_edge && start_wait != 8'h00 |=> start_wait_flag;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("start wait did not begin at frame edge");
	property p_sw_zero;
		@(posedge clk) disable iff (rst) ce && fs_edge && start_wait == 8'h00 && !start_wait_flag
			|=> !start_wait_flag;
	endproperty
	a_sw_zero: assert property (p_sw_zero) else $error("zero start wait armed");
	property p_sw_len;
		@(posedge clk) disable iff (rst) $fell(start_wait_flag) && $past(!fs_edge)
			|-> sw_len == {sw_arm, 13'h0000};
	endproperty
	a_sw_len: assert property (p_sw_len) else $error("start wait length wrong");
	property p_exc_start;
		@(posedge clk) disable iff (rst) ce && sw_done && !fs_edge && work_exc_wait[0] != 8'h00
			|=> excitation_wait_flag[0];
	endproperty
	a_exc_start: assert property (p_exc_start) else $error("excitation wait did not follow start wait");
	property p_run_after_exc;
		@(posedge clk) disable iff (rst) $rose(motor_running[1]) |-> $past(excitation_wait_flag[1]);
	endproperty
	a_run_after_exc: assert property (p_run_after_exc) else $error("motor ran without excitation wait");
	property p_cancel;
		@(posedge clk) disable iff (rst) ce && fs_edge |=> motor_running == 2'b00 && excitation_wait_flag == 2'b00;
	endproperty
	a_cancel: assert property (p_cancel) else $error("motion carried past frame edge");
	property p_pwm_min;
		@(posedge clk) disable iff (rst) pwm_period_start |=> !pwm_period_start [*7];
	endproperty
	a_pwm_min: assert property (p_pwm_min) else $error("PWM period below eight cycles");
	property p_step_gap;
		@(posedge clk) disable iff (rst) fine_step[0] |=> !fine_step[0] [*2];
	endproperty
	a_step_gap: assert property (p_step_gap) else $error("fine steps closer than three cycles");
	property p_trim_latch;
		@(posedge clk) disable iff (rst) $fell(start_wait_flag) && $past(!fs_edge)
			|-> alpha_phase_trim_active == $past(phase_trim[0]);
	endproperty
	a_trim_latch: assert property (p_trim_latch) else $error("trim not latched at start wait end");
	property p_step_total;
		@(posedge clk) disable iff (rst) $fell(motor_running[0]) && $past(!fs_edge)
			|-> tally == {work_count[0], 3'h0};
	endproperty
	a_step_total: assert property (p_step_total) else $error("fine step total per frame wrong");
	property p_zero_count;
		@(posedge clk) disable iff (rst) work_count[1] == 8'h00 && !motor_running[1] |=> !motor_running[1];
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("motor ran with zero step count");
	c_sw_end: cover property (@(posedge clk) disable iff (rst) $fell(start_wait_flag));
	c_run_done: cover property (@(posedge clk) disable iff (rst) $fell(motor_running[0]) && $past(!fs_edge));
	c_cancel: cover property (@(posedge clk) disable iff (rst) motor_running[0] && fs_edge);
endmodule
`default_nettype wire

// ---- tb/mft_host_model.sv ----
`default_nettype none
module mft_host_model
	import mft_pkg::*;
(
	input wire logic clk,
	input wire logic [15:0] reg_rd_data,
	output logic reg_wr_en,
	output logic [5:0] reg_addr,
	output logic [15:0] reg_wr_data,
	output logic focus_zoom_frame_sync
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr_en = 1'b0;
		reg_addr = 6'h00;
		reg_wr_data = 16'h0000;
		focus_zoom_frame_sync = 1'b0;
	end
	task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		// A zero start wait stalls every later update and a zero excitation wait idles the motor, so the host never sends one
		if ((a == MFT_ADDR_START_PWM || a == MFT_ADDR_ALPHA_WAIT || a == MFT_ADDR_BETA_WAIT) && v[7:0] == 8'h00) begin
			v[7:0] = 8'h01;
		end
		@(posedge clk);
		#1;
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = v;
		@(posedge clk);
		#1;
		reg_wr_en = 1'b0;
		// Released data lines do not keep the old value
		reg_wr_data = ~v;
	endtask
	task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		@(posedge clk);
		#1;
		d = reg_rd_data;
	endtask
	task automatic frame_edge();
		@(posedge clk);
		#1;
		focus_zoom_frame_sync = 1'b1;
		@(posedge clk);
		#1;
		focus_zoom_frame_sync = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/mft_frame_timing_tb_top.sv ----
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module mft_frame_timing_tb_top
	import mft_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce, sync, wr_en, pwm_period_start, start_wait_flag;
	logic [5:0] addr, atrim, btrim, trim;
	logic [15:0] wdata, rd, d, per;
	logic [1:0] exc_flag, running, fine_step, sc;
	logic [7:0] apos, bpos;
	logic [4:0] div;
	logic beta_ran = 1'b0;
	int n_errors = 0, tests_run = 0, cycles = 0, n, k, p, last, g;
	integer seed;
	logic [5:0] ad [7] = '{6'h20, 6'h22, 6'h24, 6'h25, 6'h27, 6'h29, 6'h2A};
	logic [15:0] rv [7] = '{16'h3C0A, 16'h0003, 16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000};
	logic [15:0] mk [7] = '{16'h7FFF, 16'h3FFF, 16'h00FF, 16'hFFFF, 16'h3FFF, 16'h00FF, 16'hFFFF};
	mft_host_model i_host (.clk(clk), .reg_rd_data(rd), .reg_wr_en(wr_en), .reg_addr(addr),
		.reg_wr_data(wdata), .focus_zoom_frame_sync(sync));
	mft_frame_timing i_dut (.clk(clk), .rst(rst), .ce(ce), .focus_zoom_frame_sync(sync), .reg_wr_en(wr_en),
		.reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rd), .start_wait_flag(start_wait_flag),
		.excitation_wait_flag(exc_flag), .motor_running(running), .fine_step(fine_step), .alpha_position(apos),
		.beta_position(bpos), .alpha_phase_trim_active(atrim), .beta_phase_trim_active(btrim),
		.pwm_period_start(pwm_period_start));
	function automatic int pwm_exp(input logic [4:0] dv, input logic [1:0] s);
		return ((dv == 5'h00) ? 1 : int'(dv)) * 8 * (1 << s);
	endfunction
	task automatic finish_test();
		$display("Errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic pwm_gap(output int gp);
		int w;
		w = 0;
		// Align to a pulse first so the measured gap is one whole PWM period
		@(posedge clk);
		#1;
		while (pwm_period_start !== 1'b1 && w < 3000) begin @(posedge clk); #1; w++; end
		gp = 0;
		do begin @(posedge clk); #1; gp++; end while (pwm_period_start !== 1'b1 && gp < 3000);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cuts a hang short; the longest path needs about 40000 cycles
	always @(posedge clk) begin
		cycles++;
		if (running[1] === 1'b1) beta_ran = 1'b1;
		if (cycles == 60000) begin n_errors++; finish_test(); end
	end
	initial begin
		ce = 1'b1;
		rst = 1'b1;
		seed = 32'h8EFE;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		foreach (ad[i]) begin i_host.read_reg(ad[i], d); `CHK(d, rv[i]) end
		foreach (ad[i]) begin
			i_host.write_reg(ad[i], 16'($random(seed)) | 16'h0001);
			i_host.read_reg(ad[i], d);
			`CHK(d, (wdata ^ 16'hFFFF) & mk[i])
		end
		i_host.write_reg(6'h3F, 16'($random(seed)));
		i_host.read_reg(6'h3F, d);
		`CHK(d, 16'h0000)
		per = 16'(1 + ($unsigned($random(seed)) % 4));
		trim = 6'($random(seed));
		div = 5'(1 + ($unsigned($random(seed)) % 31));
		sc = 2'($random(seed));
		i_host.write_reg(6'h20, {1'b0, sc, div, 8'h01});
		i_host.write_reg(6'h22, {2'b00, trim, 8'h01});
		i_host.write_reg(6'h24, 16'h0001);
		i_host.write_reg(6'h25, per);
		i_host.write_reg(6'h27, {2'b00, ~trim, 8'h02});
		i_host.write_reg(6'h29, 16'h0000);
		i_host.write_reg(6'h2A, per);
		i_host.frame_edge();
		k = 0;
		while (start_wait_flag !== 1'b1 && k < 10) begin @(posedge clk); #1; k++; end
		n = 0;
		while (start_wait_flag === 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end
		`CHK(n, 8192)
		`CHK(atrim, trim)
		`CHK(btrim, ~trim)
		k = 0;
		while (exc_flag[0] !== 1'b1 && k < 10) begin @(posedge clk); #1; k++; end
		n = 0;
		while (exc_flag[0] === 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end
		`CHK(n, 8192)
		`CHK(running[0], 1'b1)
		p = 0;
		last = 0;
		for (n = 1; n < 24 * per + 20; n++) begin
			@(posedge clk);
			#1;
			if (fine_step[0] === 1'b1) begin
				if (p > 0) `CHK(n - last, 3 * int'(per))
				last = n;
				p++;
			end
		end
		`CHK(p, 8)
		`CHK(running[0], 1'b0)
		`CHK(apos, 8'h08)
		`CHK(beta_ran, 1'b0)
		`CHK(bpos, 8'h00)
		pwm_gap(g);
		`CHK(g, pwm_exp(div, sc))
		i_host.write_reg(6'h20, {1'b0, sc, 5'h00, 8'h01});
		i_host.write_reg(6'h24, 16'h00FF);
		i_host.write_reg(6'h25, 16'hFFFF);
		i_host.frame_edge();
		k = 0;
		while (start_wait_flag === 1'b1 && k < 9000) begin @(posedge clk); #1; k++; end
		pwm_gap(g);
		`CHK(g, pwm_exp(5'h00, sc))
		k = 0;
		while (running[0] !== 1'b1 && k < 9000) begin @(posedge clk); #1; k++; end
		`CHK(running[0], 1'b1)
		repeat (20) @(posedge clk);
		i_host.frame_edge();
		`CHK(running[0], 1'b0)
		`CHK(start_wait_flag, 1'b1)
		finish_test();
	end
endmodule
`default_nettype wire
